// *** hdl/mul_neg_stack_core.sv ***
`timescale 1ns/1ps
// What this block does
// - multiply-by-file puts unsigned w times file in the product pair.
// - multiply-by-file leaves w, the file register and all flags alone.
// - access bit 0 picks the access bank, 1 picks the bank select bank.
// - access bit 0, extended set on and address to 5Fh use indexed mode.
// - negate-file writes the two's complement, updates five flags.
// - pop drops the top of the return stack in one cycle, no flags.
// - push puts pc plus two on the return stack in one cycle.
// - relative call pushes pc plus two, jumps by 2n, takes two cycles.
// - software reset returns registers and flags to reset values.
module mul_neg_stack_core
  import insn_group_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int PTR_W       = 5
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // instruction fetch
  input  wire logic [15:0] insn_word,
  input  wire logic        insn_valid,
  // configuration
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  w_reg,
  // data memory
  output logic [11:0]      data_addr,
  input  wire logic [7:0]  data_rdata,
  output logic             data_we,
  output logic [7:0]       data_wdata,
  // state
  output logic [20:0]      pc_q,
  output logic [20:0]      top_of_return_stack,
  output logic [PTR_W-1:0] stack_ptr_q,
  output logic [7:0]       product_high_q,
  output logic [7:0]       product_low_q,
  output logic [7:0]       status_q,
  output logic             busy,
  output logic             soft_reset_pulse
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic is_mul;
  logic is_neg;
  logic is_pop;
  logic is_push;
  logic is_call;
  logic is_reset;
  logic is_nop;
  logic indexed_mode;
  exec_state_type state_q;
  exec_state_type state_d;

  always_comb
  begin
    is_mul   = insn_word[15:9] == OP_MUL_TOP7;
    is_neg   = insn_word[15:9] == OP_NEG_TOP7;
    is_pop   = insn_word == OP_POP;
    is_push  = insn_word == OP_PUSH;
    is_call  = insn_word[15:11] == OP_REL_CALL_TOP5;
    is_reset = insn_word == OP_SW_RESET;
    is_nop   = (insn_word == OP_IDLE_ZERO) ||
               (insn_word[15:12] == OP_IDLE_TOP4);
  end

  operand_address u_addr (
    .access_sel           (insn_word[ACCESS_BIT]),
    .file_addr            (insn_word[7:0]),
    .ext_set_en           (ext_set_en),
    .bank_select_register (bank_select_register),
    .index_base           (index_base),
    .data_addr            (data_addr),
    .indexed_mode         (indexed_mode)
  );

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  function automatic logic [20:0] pc_next(input logic [20:0] pc);
    pc_next = pc + PC_STEP;
  endfunction : pc_next

  logic       exec;
  logic [7:0] neg_val;
  logic [8:0] neg_sum;
  logic [4:0] neg_low;
  logic [15:0] product;
  logic [20:0] call_target;

  always_comb
  begin
    exec      = insn_valid && (state_q == ST_EXEC);
    neg_sum   = {1'b0, ~data_rdata} + 9'h001;
    neg_val   = neg_sum[7:0];
    neg_low   = {1'b0, ~data_rdata[3:0]} + 5'h01;
    product   = {8'h00, w_reg} * {8'h00, data_rdata};
    call_target = pc_next(pc_q) +
                  {{9{insn_word[10]}}, insn_word[10:0], 1'b0};
    data_we    = exec && is_neg;
    data_wdata = neg_val;
  end

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  logic [20:0]      stack_mem [STACK_DEPTH+1];
  logic [PTR_W-1:0] stack_ptr_d;
  logic             push_en;

  always_comb
  begin
    push_en     = exec && (is_push || is_call);
    stack_ptr_d = stack_ptr_q;
    if (exec && is_reset)
      stack_ptr_d = RST_PTR;
    else if (push_en)
      stack_ptr_d = stack_ptr_q + PTR_W'(1);
    else if (exec && is_pop)
      stack_ptr_d = stack_ptr_q - PTR_W'(1);
    top_of_return_stack = stack_mem[stack_ptr_q];
  end

  // push writes the new slot; pop leaves old contents, only pointer moves
  always_ff @(posedge sys_clk)
  begin
    if (push_en)
      stack_mem[stack_ptr_q + PTR_W'(1)] <= pc_next(pc_q);
  end

  // ---------------------------------------------------------------
  // core registers
  // ---------------------------------------------------------------
  logic [20:0] pc_d;
  logic [7:0]  product_high_d;
  logic [7:0]  product_low_d;
  logic [7:0]  status_d;

  always_comb
  begin
    state_d        = state_q;
    pc_d           = pc_q;
    product_high_d = product_high_q;
    product_low_d  = product_low_q;
    status_d       = status_q;
    case (state_q)
      ST_EXEC:
      begin
        if (insn_valid)
        begin
          pc_d = pc_next(pc_q);
          if (is_reset)
          begin
            pc_d           = RST_PC;
            product_high_d = RST_BYTE;
            product_low_d  = RST_BYTE;
            status_d       = RST_BYTE;
          end
          else if (is_mul)
          begin
            product_high_d = product[15:8];
            product_low_d  = product[7:0];
          end
          else if (is_neg)
          begin
            status_d[FLAG_C]  = neg_sum[8];
            status_d[FLAG_DIGIT] = neg_low[4];
            status_d[FLAG_Z]     = neg_val == 8'h00;
            status_d[FLAG_OVF]   = data_rdata == 8'h80;
            status_d[FLAG_N]  = neg_val[7];
          end
          else if (is_call)
          begin
            pc_d    = call_target;
            state_d = ST_IDLE_CYCLE;
          end
        end
      end
      ST_IDLE_CYCLE:
        state_d = ST_EXEC;
      default:
        state_d = ST_EXEC;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_q        <= ST_EXEC;
      pc_q           <= RST_PC;
      stack_ptr_q    <= RST_PTR;
      product_high_q <= RST_BYTE;
      product_low_q  <= RST_BYTE;
      status_q       <= RST_BYTE;
    end
    else
    begin
      state_q        <= state_d;
      pc_q           <= pc_d;
      stack_ptr_q    <= stack_ptr_d;
      product_high_q <= product_high_d;
      product_low_q  <= product_low_d;
      status_q       <= status_d;
    end
  end

  always_comb
  begin
    busy             = state_q == ST_IDLE_CYCLE;
    soft_reset_pulse = exec && is_reset;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mul_product: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_mul |=> {product_high_q, product_low_q} ==
      16'($past(w_reg)) * 16'($past(data_rdata)))
    else $error("product pair wrong");
  a_mul_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_mul |=> $stable(status_q) && !$past(data_we))
    else $error("multiply changed flags or file");
  a_bank_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
    insn_word[ACCESS_BIT] |-> data_addr[11:8] ==
      bank_select_register)
    else $error("banked address wrong");
  a_indexed_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
    !insn_word[ACCESS_BIT] && ext_set_en && insn_word[7:0] <= INDEXED_MAX
      |-> indexed_mode)
    else $error("indexed mode missed");
  a_neg_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_neg |-> data_we && (data_wdata + data_rdata == 8'h00)
      ##1 status_q[FLAG_Z] == ($past(data_rdata) == 8'h00))
    else $error("negate result wrong");
  a_pop_ptr: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_pop |=> stack_ptr_q == $past(stack_ptr_q) - PTR_W'(1)
      && $stable(status_q))
    else $error("pop pointer wrong");
  a_push_top: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_push |=> top_of_return_stack == $past(pc_q) + PC_STEP
      && !busy)
    else $error("push top wrong");
  a_call_two: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_call |=> busy ##1 !busy)
    else $error("call not two cycles");
  a_reset_pc: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_reset |=> pc_q == RST_PC && stack_ptr_q == RST_PTR)
    else $error("soft reset incomplete");
  a_nop_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    exec && is_nop |=> $stable(status_q) && $stable(product_low_q)
      && $stable(stack_ptr_q))
    else $error("nop changed state");

endmodule : mul_neg_stack_core

// *** hdl/insn_group_pkg.sv ***
package insn_group_pkg;

  // ---------------------------------------------------------------
  // opcode patterns
  // ---------------------------------------------------------------
  localparam logic [15:0] OP_IDLE_ZERO     = 16'h0000;
  localparam logic [15:0] OP_POP           = 16'h0006;
  localparam logic [15:0] OP_PUSH          = 16'h0005;
  localparam logic [15:0] OP_SW_RESET      = 16'h00FF;
  localparam logic [6:0]  OP_MUL_TOP7      = 7'h01;
  localparam logic [6:0]  OP_NEG_TOP7      = 7'h36;
  localparam logic [4:0]  OP_REL_CALL_TOP5 = 5'h1B;
  localparam logic [3:0]  OP_IDLE_TOP4     = 4'hF;

  // ---------------------------------------------------------------
  // field positions and limits
  // ---------------------------------------------------------------
  localparam int          ACCESS_BIT     = 8;
  localparam logic [7:0]  INDEXED_MAX    = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;

  // ---------------------------------------------------------------
  // flag positions in the status byte
  // ---------------------------------------------------------------
  localparam int FLAG_C     = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_Z     = 2;
  localparam int FLAG_OVF   = 3;
  localparam int FLAG_N     = 4;

  // ---------------------------------------------------------------
  // reset values and pc step
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [20:0] RST_PC     = 21'h000000;
  localparam logic [4:0]  RST_PTR    = 5'h00;
  localparam logic [20:0] PC_STEP    = 21'h000002;

  typedef enum logic [1:0] {
    ST_EXEC,
    ST_IDLE_CYCLE
  } exec_state_type;

endpackage : insn_group_pkg

// *** hdl/operand_address.sv ***
`timescale 1ns/1ps
module operand_address
  import insn_group_pkg::*;
(
  // operand fields
  input  wire logic        access_sel,
  input  wire logic [7:0]  file_addr,
  input  wire logic        ext_set_en,
  // banking state
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  // resolved address
  output logic [11:0]      data_addr,
  output logic             indexed_mode
);

  always_comb
  begin
    indexed_mode = 1'b0;
    if (access_sel)
      data_addr = {bank_select_register, file_addr};
    else if (ext_set_en && (file_addr <= INDEXED_MAX))
    begin
      indexed_mode = 1'b1;
      data_addr    = index_base + {4'h0, file_addr};
    end
    else if (file_addr < ACCESS_SPLIT)
      data_addr = {4'h0, file_addr};
    else
      data_addr = {ACCESS_HI_BANK, file_addr};
  end

endmodule : operand_address

// *** bench/insn_mem_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// program memory and file registers on the far side
// ------------------------------------------------------------
module insn_mem_model
(
  // clock
  input  wire logic        sys_clk,
  // instruction fetch
  input  wire logic [20:0] pc_q,
  output logic [15:0]      insn_word,
  // data memory
  input  wire logic [11:0] data_addr,
  output logic [7:0]       data_rdata,
  input  wire logic        data_we,
  input  wire logic [7:0]  data_wdata
);
  logic [15:0] prog  [0:1023];
  logic [7:0]  fregs [0:4095];

  // only the low word address bits index, so the bench pokes ahead of pc
  assign insn_word  = prog[pc_q[10:1]];
  assign data_rdata = fregs[data_addr];

  always @(posedge sys_clk)
    if (data_we)
      fregs[data_addr] <= data_wdata;
endmodule : insn_mem_model

// *** bench/test_multiply_negate_stack_call_ops.sv ***
`timescale 1ns/1ps
module test_multiply_negate_stack_call_ops;
  import insn_group_pkg::*;
  logic sys_clk = 0, nrst = 0, insn_valid = 0, ext_set_en = 0;
  logic [15:0] insn_word;
  logic [3:0] bank_select_register = 0;
  logic [11:0] index_base = 0, data_addr;
  logic [7:0] w_reg = 0, data_rdata, data_wdata, ph, pl, status_q, st;
  logic [20:0] pc_q, top_of_return_stack, pcm;
  logic [4:0] stack_ptr_q;
  logic data_we, busy, soft_reset_pulse;
  logic [15:0] prod;
  logic [31:0] seed = 54209;
  logic [20:0] stk[$];
  int n_fail = 0, n_tests = 0, k;

  always #12.5 sys_clk = ~sys_clk;

  mul_neg_stack_core DUT (.sys_clk(sys_clk), .nrst(nrst),
    .insn_word(insn_word), .insn_valid(insn_valid),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
    .index_base(index_base), .w_reg(w_reg), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_we(data_we), .data_wdata(data_wdata),
    .pc_q(pc_q), .top_of_return_stack(top_of_return_stack),
    .stack_ptr_q(stack_ptr_q), .product_high_q(ph), .product_low_q(pl),
    .status_q(status_q), .busy(busy), .soft_reset_pulse(soft_reset_pulse));

  insn_mem_model mem (.sys_clk(sys_clk), .pc_q(pc_q), .insn_word(insn_word),
    .data_addr(data_addr), .data_rdata(data_rdata), .data_we(data_we),
    .data_wdata(data_wdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // one instruction, model updated after the taking edge
  // ------------------------------------------------------------
  task step(input int k, input logic [7:0] v, input logic [7:0] wv);
    logic [31:0] r;
    logic [15:0] iw;
    logic [11:0] ea;
    logic [7:0] f, ng;
    logic a;
    r = rnd();
    f = r[7:0];
    a = r[8];
    ext_set_en = r[9];
    bank_select_register = r[13:10];
    index_base = r[25:14];
    w_reg = wv;
    ng = ~v + 8'h01;
    if (!a && ext_set_en && f <= INDEXED_MAX)
      ea = index_base + {4'h0, f};
    else if (a)
      ea = {bank_select_register, f};
    else
      ea = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI_BANK, f};
    case (k)
      0: iw = {OP_MUL_TOP7, a, f};
      1: iw = {OP_NEG_TOP7, a, f};
      2: iw = OP_PUSH;
      3: iw = OP_POP;
      4: iw = {OP_REL_CALL_TOP5, r[26:16]};
      5: iw = OP_IDLE_ZERO;
      6: iw = {OP_IDLE_TOP4, r[27:16]};
      default: iw = OP_SW_RESET;
    endcase
    mem.prog[pcm[10:1]] = iw;
    mem.fregs[ea] = v;
    insn_valid = 1;
    @(negedge sys_clk);
    if (k < 2) chk("data_addr", data_addr, ea);
    chk("data_we", data_we, k == 1);
    if (k == 1) chk("data_wdata", data_wdata, ng);
    chk("soft_reset_pulse", soft_reset_pulse, k == 7);
    @(posedge sys_clk);
    #1;
    pcm = pcm + PC_STEP;
    case (k)
      0: prod = v * wv;
      1: st = {3'b0, ng[7], v == 8'h80, ng == 8'h00, v[3:0] == 4'h0, v == 0};
      2: stk.push_back(pcm);
      3: void'(stk.pop_back());
      4:
      begin
        stk.push_back(pcm);
        pcm = pcm + {{9{r[26]}}, r[26:16], 1'b0};
      end
      7:
      begin
        pcm = RST_PC;
        stk.delete();
        prod = 0;
        st = RST_BYTE;
      end
      default: ;
    endcase
    chk("pc", pc_q, pcm);
    chk("ptr", stack_ptr_q, stk.size());
    if (stk.size() > 0) chk("top", top_of_return_stack, stk[$]);
    chk("product", {ph, pl}, prod);
    chk("status", status_q, st);
    chk("busy", busy, k == 4);
    if (k == 4)
    begin
      // a push word offered in the idle cycle must be ignored
      mem.prog[pcm[10:1]] = OP_PUSH;
      @(posedge sys_clk);
      #1;
      chk("pc idle", pc_q, pcm);
      chk("ptr idle", stack_ptr_q, stk.size());
    end
  endtask : step

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    pcm = RST_PC;
    prod = 0;
    st = RST_BYTE;
    repeat (16) @(posedge sys_clk);
    #1;
    chk("pc reset", pc_q, RST_PC);
    chk("status reset", status_q, RST_BYTE);
    chk("product reset", {ph, pl}, 16'h0000);
    nrst = 1;
    for (int i = 0; i < 300; i++)
    begin
      k = rnd() % 8;
      if (k == 3 && stk.size() == 0)
        k = 2;
      if ((k == 2 || k == 4) && stk.size() >= 30)
        k = 3;
      step(k, 8'(rnd()), 8'(rnd()));
    end
    step(1, 8'h80, 8'h00);
    step(1, 8'h00, 8'h00);
    step(1, 8'h10, 8'h00);
    step(0, 8'hFF, 8'hFF);
    step(0, 8'h00, 8'h7F);
    insn_valid = 0;
    @(posedge sys_clk);
    #1;
    chk("pc hold", pc_q, pcm);
    report_and_stop();
  end
endmodule : test_multiply_negate_stack_call_ops
